// *** hw/bisa_pkg.sv ***
// Shared types and constants for the byte opcode decoder
package bisa_pkg;

	// ----------------------------------------------------------------
	// Instruction classes
	// ----------------------------------------------------------------
	typedef enum logic [5:0] {
		OC_NOP, OC_UNASG,
		OC_AND, OC_OR, OC_XOR, OC_AND_D, OC_OR_D, OC_XOR_D,
		OC_A_CLR, OC_A_INV, OC_A_SWAP, OC_ROL, OC_ROR, OC_ROLC, OC_RORC,
		OC_LD_A, OC_WR_REG, OC_WR_DIR, OC_WR_IND, OC_LD_DP, OC_CODE,
		OC_XRD, OC_XWR, OC_PUSH, OC_POP, OC_XCH, OC_XCH_LO,
		OC_CLR, OC_SET, OC_INV, OC_C_AND, OC_C_OR, OC_C_LD, OC_C_ST,
		OC_ABS_CALL, OC_ABS_JMP, OC_LONG_CALL, OC_RET, OC_IRET,
		OC_LONG_JMP, OC_SHORT_JMP, OC_IND_JMP,
		OC_JC, OC_JNC, OC_JB, OC_JNB, OC_JB_CLR, OC_JZ, OC_JNZ,
		OC_CMP_JNE, OC_DEC_JNZ
	} bisa_op_t;

	// ----------------------------------------------------------------
	// Operand source or address base
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		S_NONE, S_REG, S_DIR, S_IND, S_IMM, S_ACC, S_DP, S_PC,
		S_C, S_BIT, S_NBIT, S_ADDR
	} bisa_src_t;

	typedef enum {ST_IDLE, ST_EXEC} bisa_state_t;

	// ----------------------------------------------------------------
	// Length in bytes and execution time in system clocks
	// ----------------------------------------------------------------
	localparam int unsigned CNT_W = 4;
	typedef struct packed {
		logic [1:0] len;
		logic [CNT_W-1:0] cyc;
	} bisa_shape_t;

	localparam bisa_shape_t SH_1_2 = {2'h1, 4'h2};
	localparam bisa_shape_t SH_2_2 = {2'h2, 4'h2};
	localparam bisa_shape_t SH_1_4 = {2'h1, 4'h4};
	localparam bisa_shape_t SH_2_4 = {2'h2, 4'h4};
	localparam bisa_shape_t SH_3_4 = {2'h3, 4'h4};

	// ----------------------------------------------------------------
	// Opcode field positions
	// ----------------------------------------------------------------
	localparam int unsigned FLD_W = 3;
	localparam int unsigned REG_LSB = 0;
	localparam int unsigned ABS_LSB = 5;
	localparam int unsigned REG_FORM_BIT = 3;

	typedef struct packed {
		bisa_op_t op;
		bisa_src_t src;
		bisa_shape_t shape;
		logic [FLD_W-1:0] reg_idx;
		logic ind_idx;
		logic [FLD_W-1:0] abs_hi;
		logic uses_reg;
		logic uses_ind;
	} bisa_dec_t;

	localparam bisa_dec_t DEC_RST = '{op: OC_NOP, src: S_NONE, shape: SH_1_2, default: '0};
	localparam logic [CNT_W-1:0] CNT_RST = 4'h0;

endpackage : bisa_pkg

// *** hw/bisa_field_split.sv ***
// Opcode field extraction: register, indirect and absolute address bits
`timescale 1ns/1ps
module bisa_field_split (
	input wire logic [7:0] i_opcode,
	output logic [bisa_pkg::FLD_W-1:0] o_reg_idx,
	output logic [bisa_pkg::FLD_W-1:0] o_abs_hi,
	output logic o_ind_idx,
	output logic o_reg_form,
	output logic o_ind_form
);

	genvar gi;
	generate
		for (gi = 0; gi < bisa_pkg::FLD_W; gi++) begin : g_bit
			assign o_reg_idx[gi] = i_opcode[bisa_pkg::REG_LSB + gi];
			assign o_abs_hi[gi] = i_opcode[bisa_pkg::ABS_LSB + gi];
		end
	endgenerate

	assign o_ind_idx = i_opcode[0];
	assign o_reg_form = i_opcode[bisa_pkg::REG_FORM_BIT];
	assign o_ind_form = (i_opcode[3:1] == 3'h3);

endmodule : bisa_field_split

// *** hw/bisa_cycle_timer.sv ***
// Execution cycle timer: busy for a loaded number of system clocks
`timescale 1ns/1ps
module bisa_cycle_timer (
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire logic i_start,
	input wire logic [bisa_pkg::CNT_W-1:0] i_cycles,
	output logic o_busy,
	output logic o_last
);

	logic [bisa_pkg::CNT_W-1:0] cnt_q;
	logic [bisa_pkg::CNT_W-1:0] cnt_d;
	logic busy_q;
	logic busy_d;

	always_comb begin
		cnt_d = cnt_q;
		busy_d = busy_q;
		if (i_start) begin
			busy_d = 1'b1;
			cnt_d = i_cycles - 4'h1;
		end else if (busy_q) begin
			if (cnt_q == 4'h0) begin
				busy_d = 1'b0;
			end else begin
				cnt_d = cnt_q - 4'h1;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_q <= bisa_pkg::CNT_RST;
			busy_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			busy_q <= busy_d;
		end
	end

	assign o_busy = busy_q;
	assign o_last = busy_q && (cnt_q == 4'h0);

endmodule : bisa_cycle_timer

// *** hw/bisa_decoder.sv ***
// Opcode decoder with per-instruction length and execution timing
`timescale 1ns/1ps

// Function
// - Eight-code blocks pick the working register from the low three opcode bits.
// - Absolute calls x1 odd-high and jumps: two bytes, four cycles, top bits address.
// - AND into accumulator from register, direct, indirect or immediate in two cycles.
// - AND/OR/XOR into direct byte: accumulator 2B/2C, immediate 3B/4C.
// - OR into accumulator from register, direct, indirect or immediate in two cycles.
// - XOR into accumulator from register, direct, indirect or immediate in two cycles.
// - Clear, invert, nibble swap, plain rotates and no-op: one byte, two cycles.
// - Rotates through carry, left 33 and right 13, in two cycles.
// - Load accumulator from register, direct, indirect or immediate in two cycles.
// - Write working register from accumulator, direct byte or immediate.
// - Write direct byte from accumulator, register, direct, indirect or immediate.
// - Write indirect memory from accumulator, direct byte or immediate.
// - Load sixteen-bit data pointer from immediate: three bytes, four cycles.
// - Code byte read relative to data pointer or program counter, four cycles.
// - External data moves, eight or sixteen bit address, four cycles.
// - Stack push and pop of a direct byte: two bytes, four cycles.
// - Exchange accumulator with register, direct or indirect; low nibble exchange.
// - Carry and direct bit clear, set, invert; carry AND/OR with bit.
// - Direct bit to carry in two cycles, carry to bit in four.
// - Long call, return and interrupt return in four cycles.
// - Long, short relative and accumulator-plus-pointer jumps in four cycles.
// - Conditional relative jumps on carry, bit, bit-then-clear, accumulator zero.
module bisa_decoder (
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire logic i_fetch_valid,
	input wire logic [7:0] i_opcode,
	output logic o_fetch_ready,
	output logic o_dec_valid,
	output bisa_pkg::bisa_dec_t o_dec,
	output logic o_exec_busy,
	output logic o_exec_done
);

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	bisa_pkg::bisa_state_t state_q;
	bisa_pkg::bisa_state_t state_d;
	bisa_pkg::bisa_dec_t dec_q;
	bisa_pkg::bisa_dec_t dec_d;
	bisa_pkg::bisa_dec_t tbl;
	logic ready_q;
	logic ready_d;
	logic dvalid_q;
	logic dvalid_d;
	logic done_q;
	logic done_d;
	logic take;
	logic t_last;
	logic [bisa_pkg::FLD_W-1:0] f_reg;
	logic [bisa_pkg::FLD_W-1:0] f_abs;
	logic f_ind;
	logic f_reg_form;
	logic f_ind_form;

	assign take = i_fetch_valid && ready_q;

	bisa_field_split u_split (
		.i_opcode(i_opcode),
		.o_reg_idx(f_reg),
		.o_abs_hi(f_abs),
		.o_ind_idx(f_ind),
		.o_reg_form(f_reg_form),
		.o_ind_form(f_ind_form)
	);

	bisa_cycle_timer u_timer (
		.i_core_clk(i_core_clk),
		.i_rstn(i_rstn),
		.i_start(take),
		.i_cycles(tbl.shape.cyc),
		.o_busy(o_exec_busy),
		.o_last(t_last)
	);

	function automatic bisa_pkg::bisa_dec_t ent(input bisa_pkg::bisa_op_t c,
		input bisa_pkg::bisa_src_t s, input bisa_pkg::bisa_shape_t h);
		bisa_pkg::bisa_dec_t r;
		r = bisa_pkg::DEC_RST;
		r.op = c;
		r.src = s;
		r.shape = h;
		return r;
	endfunction : ent

	// ----------------------------------------------------------------
	// Opcode table
	// ----------------------------------------------------------------
	always_comb begin
		casez (i_opcode)
			8'h00: tbl = ent(bisa_pkg::OC_NOP, bisa_pkg::S_NONE, bisa_pkg::SH_1_2);
			// Logical into accumulator
			8'b0101_1???: tbl = ent(bisa_pkg::OC_AND, bisa_pkg::S_REG, bisa_pkg::SH_1_2);
			8'h55: tbl = ent(bisa_pkg::OC_AND, bisa_pkg::S_DIR, bisa_pkg::SH_2_2);
			8'b0101_011?: tbl = ent(bisa_pkg::OC_AND, bisa_pkg::S_IND, bisa_pkg::SH_1_2);
			8'h54: tbl = ent(bisa_pkg::OC_AND, bisa_pkg::S_IMM, bisa_pkg::SH_2_2);
			8'b0100_1???: tbl = ent(bisa_pkg::OC_OR, bisa_pkg::S_REG, bisa_pkg::SH_1_2);
			8'h45: tbl = ent(bisa_pkg::OC_OR, bisa_pkg::S_DIR, bisa_pkg::SH_2_2);
			8'b0100_011?: tbl = ent(bisa_pkg::OC_OR, bisa_pkg::S_IND, bisa_pkg::SH_1_2);
			8'h44: tbl = ent(bisa_pkg::OC_OR, bisa_pkg::S_IMM, bisa_pkg::SH_2_2);
			8'b0110_1???: tbl = ent(bisa_pkg::OC_XOR, bisa_pkg::S_REG, bisa_pkg::SH_1_2);
			8'h65: tbl = ent(bisa_pkg::OC_XOR, bisa_pkg::S_DIR, bisa_pkg::SH_2_2);
			8'b0110_011?: tbl = ent(bisa_pkg::OC_XOR, bisa_pkg::S_IND, bisa_pkg::SH_1_2);
			8'h64: tbl = ent(bisa_pkg::OC_XOR, bisa_pkg::S_IMM, bisa_pkg::SH_2_2);
			// Logical into direct byte
			8'h52: tbl = ent(bisa_pkg::OC_AND_D, bisa_pkg::S_ACC, bisa_pkg::SH_2_2);
			8'h53: tbl = ent(bisa_pkg::OC_AND_D, bisa_pkg::S_IMM, bisa_pkg::SH_3_4);
			8'h42: tbl = ent(bisa_pkg::OC_OR_D, bisa_pkg::S_ACC, bisa_pkg::SH_2_2);
			8'h43: tbl = ent(bisa_pkg::OC_OR_D, bisa_pkg::S_IMM, bisa_pkg::SH_3_4);
			8'h62: tbl = ent(bisa_pkg::OC_XOR_D, bisa_pkg::S_ACC, bisa_pkg::SH_2_2);
			8'h63: tbl = ent(bisa_pkg::OC_XOR_D, bisa_pkg::S_IMM, bisa_pkg::SH_3_4);
			// Accumulator only
			8'hE4: tbl = ent(bisa_pkg::OC_A_CLR, bisa_pkg::S_ACC, bisa_pkg::SH_1_2);
			8'hF4: tbl = ent(bisa_pkg::OC_A_INV, bisa_pkg::S_ACC, bisa_pkg::SH_1_2);
			8'hC4: tbl = ent(bisa_pkg::OC_A_SWAP, bisa_pkg::S_ACC, bisa_pkg::SH_1_2);
			8'h23: tbl = ent(bisa_pkg::OC_ROL, bisa_pkg::S_ACC, bisa_pkg::SH_1_2);
			8'h03: tbl = ent(bisa_pkg::OC_ROR, bisa_pkg::S_ACC, bisa_pkg::SH_1_2);
			8'h33: tbl = ent(bisa_pkg::OC_ROLC, bisa_pkg::S_C, bisa_pkg::SH_1_2);
			8'h13: tbl = ent(bisa_pkg::OC_RORC, bisa_pkg::S_C, bisa_pkg::SH_1_2);
			// Data transfer
			8'b1110_1???: tbl = ent(bisa_pkg::OC_LD_A, bisa_pkg::S_REG, bisa_pkg::SH_1_2);
			8'hE5: tbl = ent(bisa_pkg::OC_LD_A, bisa_pkg::S_DIR, bisa_pkg::SH_2_2);
			8'b1110_011?: tbl = ent(bisa_pkg::OC_LD_A, bisa_pkg::S_IND, bisa_pkg::SH_1_2);
			8'h74: tbl = ent(bisa_pkg::OC_LD_A, bisa_pkg::S_IMM, bisa_pkg::SH_2_2);
			8'b1111_1???: tbl = ent(bisa_pkg::OC_WR_REG, bisa_pkg::S_ACC, bisa_pkg::SH_1_2);
			8'b1010_1???: tbl = ent(bisa_pkg::OC_WR_REG, bisa_pkg::S_DIR, bisa_pkg::SH_2_4);
			8'b0111_1???: tbl = ent(bisa_pkg::OC_WR_REG, bisa_pkg::S_IMM, bisa_pkg::SH_2_2);
			8'hF5: tbl = ent(bisa_pkg::OC_WR_DIR, bisa_pkg::S_ACC, bisa_pkg::SH_2_2);
			8'b1000_1???: tbl = ent(bisa_pkg::OC_WR_DIR, bisa_pkg::S_REG, bisa_pkg::SH_2_4);
			8'h85: tbl = ent(bisa_pkg::OC_WR_DIR, bisa_pkg::S_DIR, bisa_pkg::SH_3_4);
			8'b1000_011?: tbl = ent(bisa_pkg::OC_WR_DIR, bisa_pkg::S_IND, bisa_pkg::SH_2_4);
			8'h75: tbl = ent(bisa_pkg::OC_WR_DIR, bisa_pkg::S_IMM, bisa_pkg::SH_3_4);
			8'b1111_011?: tbl = ent(bisa_pkg::OC_WR_IND, bisa_pkg::S_ACC, bisa_pkg::SH_1_2);
			8'b1010_011?: tbl = ent(bisa_pkg::OC_WR_IND, bisa_pkg::S_DIR, bisa_pkg::SH_2_4);
			8'b0111_011?: tbl = ent(bisa_pkg::OC_WR_IND, bisa_pkg::S_IMM, bisa_pkg::SH_2_2);
			8'h90: tbl = ent(bisa_pkg::OC_LD_DP, bisa_pkg::S_IMM, bisa_pkg::SH_3_4);
			8'h93: tbl = ent(bisa_pkg::OC_CODE, bisa_pkg::S_DP, bisa_pkg::SH_1_4);
			8'h83: tbl = ent(bisa_pkg::OC_CODE, bisa_pkg::S_PC, bisa_pkg::SH_1_4);
			8'b1110_001?: tbl = ent(bisa_pkg::OC_XRD, bisa_pkg::S_IND, bisa_pkg::SH_1_4);
			8'hE0: tbl = ent(bisa_pkg::OC_XRD, bisa_pkg::S_DP, bisa_pkg::SH_1_4);
			8'b1111_001?: tbl = ent(bisa_pkg::OC_XWR, bisa_pkg::S_IND, bisa_pkg::SH_1_4);
			8'hF0: tbl = ent(bisa_pkg::OC_XWR, bisa_pkg::S_DP, bisa_pkg::SH_1_4);
			8'hC0: tbl = ent(bisa_pkg::OC_PUSH, bisa_pkg::S_DIR, bisa_pkg::SH_2_4);
			8'hD0: tbl = ent(bisa_pkg::OC_POP, bisa_pkg::S_DIR, bisa_pkg::SH_2_4);
			8'b1100_1???: tbl = ent(bisa_pkg::OC_XCH, bisa_pkg::S_REG, bisa_pkg::SH_1_2);
			8'hC5: tbl = ent(bisa_pkg::OC_XCH, bisa_pkg::S_DIR, bisa_pkg::SH_2_2);
			8'b1100_011?: tbl = ent(bisa_pkg::OC_XCH, bisa_pkg::S_IND, bisa_pkg::SH_1_2);
			8'b1101_011?: tbl = ent(bisa_pkg::OC_XCH_LO, bisa_pkg::S_IND, bisa_pkg::SH_1_2);
			// Boolean
			8'hC3: tbl = ent(bisa_pkg::OC_CLR, bisa_pkg::S_C, bisa_pkg::SH_1_2);
			8'hC2: tbl = ent(bisa_pkg::OC_CLR, bisa_pkg::S_BIT, bisa_pkg::SH_2_2);
			8'hD3: tbl = ent(bisa_pkg::OC_SET, bisa_pkg::S_C, bisa_pkg::SH_1_2);
			8'hD2: tbl = ent(bisa_pkg::OC_SET, bisa_pkg::S_BIT, bisa_pkg::SH_2_2);
			8'hB3: tbl = ent(bisa_pkg::OC_INV, bisa_pkg::S_C, bisa_pkg::SH_1_2);
			8'hB2: tbl = ent(bisa_pkg::OC_INV, bisa_pkg::S_BIT, bisa_pkg::SH_2_2);
			8'h82: tbl = ent(bisa_pkg::OC_C_AND, bisa_pkg::S_BIT, bisa_pkg::SH_2_4);
			8'hB0: tbl = ent(bisa_pkg::OC_C_AND, bisa_pkg::S_NBIT, bisa_pkg::SH_2_4);
			8'h72: tbl = ent(bisa_pkg::OC_C_OR, bisa_pkg::S_BIT, bisa_pkg::SH_2_4);
			8'hA0: tbl = ent(bisa_pkg::OC_C_OR, bisa_pkg::S_NBIT, bisa_pkg::SH_2_4);
			8'hA2: tbl = ent(bisa_pkg::OC_C_LD, bisa_pkg::S_BIT, bisa_pkg::SH_2_2);
			8'h92: tbl = ent(bisa_pkg::OC_C_ST, bisa_pkg::S_C, bisa_pkg::SH_2_4);
			// Branching
			8'b???1_0001: tbl = ent(bisa_pkg::OC_ABS_CALL, bisa_pkg::S_ADDR, bisa_pkg::SH_2_4);
			8'b???0_0001: tbl = ent(bisa_pkg::OC_ABS_JMP, bisa_pkg::S_ADDR, bisa_pkg::SH_2_4);
			8'h12: tbl = ent(bisa_pkg::OC_LONG_CALL, bisa_pkg::S_ADDR, bisa_pkg::SH_3_4);
			8'h22: tbl = ent(bisa_pkg::OC_RET, bisa_pkg::S_NONE, bisa_pkg::SH_1_4);
			8'h32: tbl = ent(bisa_pkg::OC_IRET, bisa_pkg::S_NONE, bisa_pkg::SH_1_4);
			8'h02: tbl = ent(bisa_pkg::OC_LONG_JMP, bisa_pkg::S_ADDR, bisa_pkg::SH_3_4);
			8'h80: tbl = ent(bisa_pkg::OC_SHORT_JMP, bisa_pkg::S_ADDR, bisa_pkg::SH_2_4);
			8'h73: tbl = ent(bisa_pkg::OC_IND_JMP, bisa_pkg::S_DP, bisa_pkg::SH_1_4);
			8'h40: tbl = ent(bisa_pkg::OC_JC, bisa_pkg::S_C, bisa_pkg::SH_2_4);
			8'h50: tbl = ent(bisa_pkg::OC_JNC, bisa_pkg::S_C, bisa_pkg::SH_2_4);
			8'h20: tbl = ent(bisa_pkg::OC_JB, bisa_pkg::S_BIT, bisa_pkg::SH_3_4);
			8'h30: tbl = ent(bisa_pkg::OC_JNB, bisa_pkg::S_BIT, bisa_pkg::SH_3_4);
			8'h10: tbl = ent(bisa_pkg::OC_JB_CLR, bisa_pkg::S_BIT, bisa_pkg::SH_3_4);
			8'h60: tbl = ent(bisa_pkg::OC_JZ, bisa_pkg::S_ACC, bisa_pkg::SH_2_4);
			8'h70: tbl = ent(bisa_pkg::OC_JNZ, bisa_pkg::S_ACC, bisa_pkg::SH_2_4);
			8'hB5: tbl = ent(bisa_pkg::OC_CMP_JNE, bisa_pkg::S_DIR, bisa_pkg::SH_3_4);
			8'hB4: tbl = ent(bisa_pkg::OC_CMP_JNE, bisa_pkg::S_IMM, bisa_pkg::SH_3_4);
			8'b1011_1???: tbl = ent(bisa_pkg::OC_CMP_JNE, bisa_pkg::S_REG, bisa_pkg::SH_3_4);
			8'b1011_011?: tbl = ent(bisa_pkg::OC_CMP_JNE, bisa_pkg::S_IND, bisa_pkg::SH_3_4);
			8'b1101_1???: tbl = ent(bisa_pkg::OC_DEC_JNZ, bisa_pkg::S_REG, bisa_pkg::SH_2_4);
			8'hD5: tbl = ent(bisa_pkg::OC_DEC_JNZ, bisa_pkg::S_DIR, bisa_pkg::SH_3_4);
			default: tbl = ent(bisa_pkg::OC_UNASG, bisa_pkg::S_NONE, bisa_pkg::SH_1_2);
		endcase
	end

	// ----------------------------------------------------------------
	// Accept and execute sequencing
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		dec_d = dec_q;
		ready_d = ready_q;
		dvalid_d = 1'b0;
		done_d = 1'b0;
		case (state_q)
			bisa_pkg::ST_IDLE: begin
				if (take) begin
					dec_d = tbl;
					dec_d.reg_idx = f_reg;
					dec_d.abs_hi = f_abs;
					dec_d.ind_idx = f_ind;
					dec_d.uses_reg = f_reg_form && (tbl.op != bisa_pkg::OC_UNASG);
					dec_d.uses_ind = (f_ind_form || tbl.src == bisa_pkg::S_IND)
						&& (tbl.op != bisa_pkg::OC_UNASG);
					dvalid_d = 1'b1;
					ready_d = 1'b0;
					state_d = bisa_pkg::ST_EXEC;
				end
			end
			bisa_pkg::ST_EXEC: begin
				// Released one clock after the last busy cycle
				if (t_last) begin
					ready_d = 1'b1;
					done_d = 1'b1;
					state_d = bisa_pkg::ST_IDLE;
				end
			end
			default: begin
				state_d = bisa_pkg::ST_IDLE;
				ready_d = 1'b1;
			end
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_q <= bisa_pkg::ST_IDLE;
			dec_q <= bisa_pkg::DEC_RST;
			ready_q <= 1'b1;
			dvalid_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			state_q <= state_d;
			dec_q <= dec_d;
			ready_q <= ready_d;
			dvalid_q <= dvalid_d;
			done_q <= done_d;
		end
	end

	assign o_fetch_ready = ready_q;
	assign o_dec_valid = dvalid_q;
	assign o_dec = dec_q;
	assign o_exec_done = done_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rstn);

	sequence s_take(logic [7:0] op);
		i_fetch_valid && o_fetch_ready && (i_opcode == op);
	endsequence

	sequence s_run2;
		o_exec_busy [*2] ##1 (!o_exec_busy && o_exec_done && o_fetch_ready);
	endsequence

	sequence s_run4;
		o_exec_busy [*4] ##1 (!o_exec_busy && o_exec_done && o_fetch_ready);
	endsequence

	AST_REG_FIELD: assert property (
		(i_fetch_valid && o_fetch_ready && i_opcode[7:3] == 5'h1D)
		|=> o_dec_valid && o_dec.uses_reg && o_dec.reg_idx == $past(i_opcode[2:0]))
		else $error("register index not taken from low opcode bits");

	AST_ABS_CALL: assert property (
		(i_fetch_valid && o_fetch_ready && i_opcode[4:0] == 5'h11)
		|=> o_dec.op == bisa_pkg::OC_ABS_CALL && o_dec.shape == bisa_pkg::SH_2_4
		&& o_dec.abs_hi == $past(i_opcode[7:5]))
		else $error("absolute call decode wrong");

	AST_AND_ACC: assert property (
		s_take(8'h54) |=> o_dec.op == bisa_pkg::OC_AND && o_dec.src == bisa_pkg::S_IMM
		&& o_dec.shape == bisa_pkg::SH_2_2 ##0 s_run2)
		else $error("AND immediate decode or timing wrong");

	AST_XOR_DIR_IMM: assert property (
		s_take(8'h63) |=> o_dec.op == bisa_pkg::OC_XOR_D && o_dec.shape.len == 2'h3 ##0 s_run4)
		else $error("XOR immediate to direct decode or timing wrong");

	AST_ROT_CARRY: assert property (
		s_take(8'h13) |=> o_dec.op == bisa_pkg::OC_RORC && o_dec.shape == bisa_pkg::SH_1_2)
		else $error("rotate right through carry decode wrong");

	AST_LOAD_DP: assert property (
		s_take(8'h90) |=> o_dec.op == bisa_pkg::OC_LD_DP && o_dec.shape == bisa_pkg::SH_3_4)
		else $error("data pointer load decode wrong");

	AST_EXT_READ: assert property (
		s_take(8'hE3) |=> o_dec.op == bisa_pkg::OC_XRD && o_dec.uses_ind
		&& o_dec.ind_idx ##0 s_run4)
		else $error("external read decode or timing wrong");

	AST_LONG_JUMP: assert property (
		s_take(8'h02) |=> s_run4)
		else $error("long jump not four cycles");

	AST_BIT_CLR_JUMP: assert property (
		s_take(8'h10) |=> o_dec.op == bisa_pkg::OC_JB_CLR && o_dec.shape == bisa_pkg::SH_3_4)
		else $error("jump bit set then clear decode wrong");

	AST_NOP: assert property (
		s_take(8'h00) |=> o_dec.op == bisa_pkg::OC_NOP ##0 s_run2)
		else $error("no-operation not two cycles");

	AST_UNASSIGNED: assert property (
		s_take(8'h28) |=> o_dec.op == bisa_pkg::OC_UNASG && !o_dec.uses_reg
		&& !o_dec.uses_ind ##0 s_run2)
		else $error("unassigned opcode not a two-cycle no-operation");

	AST_NO_TAKE_BUSY: assert property (
		o_exec_busy |-> !o_fetch_ready)
		else $error("fetch ready while executing");

endmodule : bisa_decoder

// *** sim/bisa_fetch_model.sv ***
// Fetch path model that offers opcode bytes to the decoder
`timescale 1ns/1ps
module bisa_fetch_model (
	input wire logic i_core_clk,
	input wire logic i_ready,
	output logic o_valid,
	output logic [7:0] o_opcode
);
	initial begin
		o_valid = 1'b0;
		o_opcode = 8'h00;
	end
	// Called just after a falling edge; holds the byte until a rising edge sees ready
	task automatic offer(input logic [7:0] op, output int waits);
		waits = 0;
		o_valid = 1'b1;
		o_opcode = op;
		forever begin
			@(posedge i_core_clk);
			if (i_ready === 1'b1 || waits >= 40) break;
			waits++;
		end
		@(negedge i_core_clk);
		o_valid = 1'b0;
		// Released byte shows its inverse so a stale value is never mistaken for data
		o_opcode = ~op;
	endtask : offer
endmodule : bisa_fetch_model

// *** sim/tb_top.sv ***
// Self-checking bench for the opcode decoder
`timescale 1ns/1ps
module tb_top;
	logic i_core_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic fetch_valid, fetch_ready, dec_valid, busy, done;
	logic [7:0] opcode;
	bisa_pkg::bisa_dec_t dec;
	int n_fail = 0;
	int num_checks = 0;
	// Entries are {opcode, bytes, cycles}
	logic [15:0] tbl [] = '{
		16'hE812, 16'hEF12, 16'hCB12,
		16'h1124, 16'hF124, 16'h0124, 16'hE124,
		16'h5812, 16'h5F12, 16'h5522, 16'h5612, 16'h5422,
		16'h5222, 16'h5334, 16'h4222, 16'h4334, 16'h6222, 16'h6334,
		16'h4812, 16'h4522, 16'h4712, 16'h4422,
		16'h6F12, 16'h6522, 16'h6612, 16'h6422,
		16'hE412, 16'hF412, 16'hC412, 16'h2312, 16'h0312, 16'h0012,
		16'h3312, 16'h1312,
		16'hE522, 16'hE712, 16'h7422,
		16'hF812, 16'hA824, 16'h7F22,
		16'hF522, 16'h8824, 16'h8534, 16'h8624, 16'h7534,
		16'hF612, 16'hA624, 16'h7722,
		16'h9034,
		16'h9314, 16'h8314,
		16'hE014, 16'hF014, 16'hE214, 16'hF314,
		16'hC024, 16'hD024,
		16'hC812, 16'hC522, 16'hC712, 16'hD612,
		16'hC312, 16'hD312, 16'hB312, 16'hC222, 16'hD222, 16'hB222,
		16'h8224, 16'hB024, 16'h7224, 16'hA024,
		16'hA222, 16'h9224,
		16'h1234, 16'h2214, 16'h3214,
		16'h0234, 16'h8024, 16'h7314,
		16'h4024, 16'h5024, 16'h2034, 16'h3034, 16'h1034, 16'h6024, 16'h7024,
		16'hB534, 16'hB434, 16'hB834, 16'hB634, 16'hD824, 16'hD534,
		16'hA512, 16'h2412, 16'h8412
	};

	bisa_decoder dut_u (
		.i_core_clk(i_core_clk),
		.i_rstn(i_rstn),
		.i_fetch_valid(fetch_valid),
		.i_opcode(opcode),
		.o_fetch_ready(fetch_ready),
		.o_dec_valid(dec_valid),
		.o_dec(dec),
		.o_exec_busy(busy),
		.o_exec_done(done)
	);
	bisa_fetch_model src_u (
		.i_core_clk(i_core_clk),
		.i_ready(fetch_ready),
		.o_valid(fetch_valid),
		.o_opcode(opcode)
	);

	initial begin
		forever #20 i_core_clk = ~i_core_clk;
	end

	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : close_out

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	// Busy must last exactly the given cycles, then done and ready together
	task automatic finish(input int cyc);
		int n;
		n = 0;
		while (busy === 1'b1 && n < 20) begin
			n++;
			@(negedge i_core_clk);
			if (n == 1) check(32'(dec_valid), 32'h0);
		end
		if (n >= 20) begin
			n_fail++;
			close_out();
		end
		check(32'(n), 32'(cyc));
		check(32'({done, fetch_ready}), 32'h3);
	endtask : finish

	task automatic run(input logic [15:0] e);
		int w;
		src_u.offer(e[15:8], w);
		if (w >= 40) begin
			n_fail++;
			close_out();
		end
		check(32'(dec_valid), 32'h1);
		check(32'(dec.shape.len), 32'(e[7:4]));
		check(32'(dec.shape.cyc), 32'(e[3:0]));
		check(32'(dec.reg_idx), 32'(e[10:8]));
		check(32'(dec.abs_hi), 32'(e[15:13]));
		finish(int'(e[3:0]));
	endtask : run

	task automatic test_table();
		foreach (tbl[i]) run(tbl[i]);
		$display("table test ended");
	endtask : test_table

	task automatic test_classes();
		run(16'h3312);
		check(32'(dec.op), 32'(bisa_pkg::OC_ROLC));
		run(16'h1312);
		check(32'(dec.op), 32'(bisa_pkg::OC_RORC));
		run(16'h3124);
		check(32'(dec.op), 32'(bisa_pkg::OC_ABS_CALL));
		run(16'hA124);
		check(32'(dec.op), 32'(bisa_pkg::OC_ABS_JMP));
		run(16'hD712);
		check(32'(dec.op), 32'(bisa_pkg::OC_XCH_LO));
		// Opcode bit 3 set, yet an unassigned code claims no working register
		run(16'h2812);
		check(32'(dec.op), 32'(bisa_pkg::OC_UNASG));
		check(32'(dec.uses_reg), 32'h0);
		$display("class test ended");
	endtask : test_classes

	// An offer made while busy is held off until the timer has finished
	task automatic test_refuse();
		int w;
		src_u.offer(8'h02, w);
		check(32'(w), 32'h0);
		check(32'(dec.op), 32'(bisa_pkg::OC_LONG_JMP));
		@(negedge i_core_clk);
		src_u.offer(8'h00, w);
		check(32'(w), 32'h3);
		check(32'(dec.op), 32'(bisa_pkg::OC_NOP));
		finish(2);
		$display("refusal test ended");
	endtask : test_refuse

	task automatic test_reset();
		int w;
		src_u.offer(8'h90, w);
		i_rstn = 1'b0;
		@(negedge i_core_clk);
		check(32'({fetch_ready, dec_valid, busy, done}), 32'h8);
		check(32'(dec), 32'(bisa_pkg::DEC_RST));
		i_rstn = 1'b1;
		run(16'h9034);
		$display("reset test ended");
	endtask : test_reset

	initial begin
		repeat (16) @(negedge i_core_clk);
		check(32'({fetch_ready, dec_valid, busy, done}), 32'h8);
		i_rstn = 1'b1;
		test_table();
		test_classes();
		test_refuse();
		test_reset();
		close_out();
	end
endmodule : tb_top
